//--- verilog/cmpc_top.sv
// Purpose: Digital control of a dual comparator with output routing, timer gate and reference.
// Assumes: Raw comparator results and the gate pin are asynchronous; timer clock level,
//          direction bits and port data come from logic on core_clk.
// Notes:   Register reads answer one cycle after the read strobe.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "cmpc_params.svh"

module cmpc_top (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire cmpc_pkg::cmpc_req_s regReq,
    output logic [7:0]             regRdata,
    input  wire logic              cmp1Raw,
    input  wire logic              cmp2Raw,
    input  wire logic [1:0]        pinDirectionBits,
    input  wire logic [1:0]        portData,
    output logic                   cmp1OutPin,
    output logic                   cmp1OutPinOe,
    output logic                   cmp2OutPin,
    output logic                   cmp2OutPinOe,
    input  wire logic              timerGatePin,
    input  wire logic              timerClockLevel,
    output logic                   timerGate,
    output logic                   timerIncrement,
    output logic [2:0]             comparatorModeSelect,
    output logic                   comparatorInputSwitch,
    output cmpc_pkg::cmpc_ref_s    referenceVoltageOut,
    input  wire logic              sleepMode,
    output logic                   cmpIrq,
    output logic                   wakeRequest,
    output logic                   vectorToIrq
);

    logic [7:0] ctrl_reg;
    logic [7:0] config_reg;
    logic [7:0] ref_reg;
    logic [1:0] flag_reg;
    logic [1:0] flag_next;
    logic [1:0] irqEn_reg;
    logic       gie_reg;
    logic       peripheral_irq_enable_reg;
    logic       route_reg;
    logic [1:0] rawMeta_reg;
    logic [1:0] rawSync_reg;
    logic [1:0] gateMeta_reg;
    logic       gatePinSync;
    logic [1:0] snapshot_reg;
    logic       cmp2Latched_reg;
    logic       timerClkPrev_reg;
    logic [1:0] cmpOut;
    logic [1:0] cmpOutRaw;
    logic       ctrlAccess;
    logic       ctrlWrite;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction : hit

    assign ctrlWrite  = regReq.wr && hit(regReq.addr, `CMPC_ADDR_CMP_CTRL);
    assign ctrlAccess = (regReq.wr || regReq.rd) && hit(regReq.addr, `CMPC_ADDR_CMP_CTRL);

    // Polarity applied after the analog result
    assign cmpOutRaw = {cmp2Raw ^ ctrl_reg[`CMPC_BIT_INV2],
                        cmp1Raw ^ ctrl_reg[`CMPC_BIT_INV1]};
    assign cmpOut    = rawSync_reg ^ {ctrl_reg[`CMPC_BIT_INV2], ctrl_reg[`CMPC_BIT_INV1]};

    // Two-stage synchronisers for asynchronous inputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rawMeta_reg <= 2'h0;
            rawSync_reg <= 2'h0;
        end else begin
            rawMeta_reg <= {cmp2Raw, cmp1Raw};
            rawSync_reg <= rawMeta_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            gateMeta_reg <= 2'h3;
        end else begin
            gateMeta_reg <= {gateMeta_reg[0], timerGatePin};
        end
    end
    assign gatePinSync = gateMeta_reg[1];

    // Control register; sleep and wake never touch it
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_reg <= `CMPC_CTRL_RESET;
        end else if (ctrlWrite) begin
            ctrl_reg <= {2'h0, regReq.wdata[5:0]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            config_reg <= `CMPC_CONFIG_RESET;
        end else if (regReq.wr && hit(regReq.addr, `CMPC_ADDR_CMP_CONFIG)) begin
            config_reg <= {6'h00, regReq.wdata[1:0]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ref_reg <= `CMPC_REF_RESET;
        end else if (regReq.wr && hit(regReq.addr, `CMPC_ADDR_REF_CTRL)) begin
            ref_reg <= regReq.wdata & `CMPC_REF_WMASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irqEn_reg <= 2'h0;
            gie_reg   <= 1'b0;
            peripheral_irq_enable_reg  <= 1'b0;
            route_reg <= 1'b0;
        end else begin
            if (regReq.wr && hit(regReq.addr, `CMPC_ADDR_PERI_EN)) begin
                irqEn_reg <= regReq.wdata[`CMPC_BIT_FLAG2:`CMPC_BIT_FLAG1];
            end
            if (regReq.wr && hit(regReq.addr, `CMPC_ADDR_IRQ_CTRL)) begin
                gie_reg  <= regReq.wdata[`CMPC_BIT_GIE];
                peripheral_irq_enable_reg <= regReq.wdata[`CMPC_BIT_PERIPHERAL_IRQ_ENABLE];
            end
            if (regReq.wr && hit(regReq.addr, `CMPC_ADDR_ROUTE_CTRL)) begin
                route_reg <= regReq.wdata[`CMPC_BIT_ROUTE_EN];
            end
        end
    end

    // Snapshot of the outputs; any access to the control register ends a mismatch.
    // A change landing in the access cycle is absorbed and raises no flag.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            snapshot_reg <= 2'h0;
        end else if (ctrlAccess) begin
            snapshot_reg <= cmpOut;
        end
    end

    // Software write sets or clears; a mismatch in the same cycle wins over a clear
    always_comb begin
        flag_next = flag_reg;
        if (regReq.wr && hit(regReq.addr, `CMPC_ADDR_PERI_FLAG)) begin
            flag_next = regReq.wdata[`CMPC_BIT_FLAG2:`CMPC_BIT_FLAG1];
        end
        if (!ctrlAccess) begin
            flag_next = flag_next | (cmpOut ^ snapshot_reg);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flag_reg <= 2'h0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Flags keep setting without enables; only the request is gated
    assign wakeRequest = |(flag_reg & irqEn_reg) && peripheral_irq_enable_reg && sleepMode;
    assign cmpIrq      = |(flag_reg & irqEn_reg) && peripheral_irq_enable_reg && gie_reg;
    assign vectorToIrq = wakeRequest && gie_reg;

    // Timer clock edges: latch on falling, count on rising, so they never race.
    // The level is the prescaler output when the timer uses one.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            timerClkPrev_reg <= 1'b0;
        end else begin
            timerClkPrev_reg <= timerClockLevel;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cmp2Latched_reg <= 1'b0;
        end else if (timerClkPrev_reg && !timerClockLevel) begin
            cmp2Latched_reg <= cmpOut[1];
        end
    end

    assign timerIncrement = !timerClkPrev_reg && timerClockLevel;

    // Sync off passes comparator 2 through; sync on (advised when gating) passes the latch
    always_comb begin
        if (config_reg[`CMPC_BIT_GATE_SEL]) begin
            timerGate = gatePinSync;
        end else if (config_reg[`CMPC_BIT_SYNC]) begin
            timerGate = cmp2Latched_reg;
        end else begin
            timerGate = cmpOut[1];
        end
    end

    // Routed pins take the unsynchronised result; direction bits remain the enables
    assign cmp1OutPin   = route_reg ? cmpOutRaw[0] : portData[0];
    assign cmp2OutPin   = route_reg ? cmpOutRaw[1] : portData[1];
    assign cmp1OutPinOe = !pinDirectionBits[0];
    assign cmp2OutPinOe = !pinDirectionBits[1];

    assign comparatorModeSelect  = ctrl_reg[2:0];
    assign comparatorInputSwitch = ctrl_reg[`CMPC_BIT_INSW];

    // Reference ladder in 1/96 steps; disabled means ground and no ladder current
    always_comb begin
        referenceVoltageOut.ladderOn  = ref_reg[`CMPC_BIT_REF_EN];
        referenceVoltageOut.rangeLow  = ref_reg[`CMPC_BIT_REF_RANGE];
        referenceVoltageOut.levelCode = ref_reg[3:0];
        if (!ref_reg[`CMPC_BIT_REF_EN]) begin
            referenceVoltageOut.level96 = 8'h00;
        end else if (ref_reg[`CMPC_BIT_REF_RANGE]) begin
            referenceVoltageOut.level96 = 8'({4'h0, ref_reg[3:0]} * `CMPC_REF_LOW_STEP);
        end else begin
            referenceVoltageOut.level96 = 8'(`CMPC_REF_HIGH_BASE
                + {4'h0, ref_reg[3:0]} * `CMPC_REF_HIGH_STEP);
        end
    end

    // Read data one cycle after the strobe, zero otherwise and for unmapped addresses
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            regRdata <= 8'h00;
        end else if (regReq.rd) begin
            unique case (regReq.addr)
                `CMPC_ADDR_CMP_CTRL:   regRdata <= {cmpOut, ctrl_reg[5:0]};
                `CMPC_ADDR_CMP_CONFIG: regRdata <= config_reg;
                `CMPC_ADDR_REF_CTRL:   regRdata <= ref_reg;
                `CMPC_ADDR_PERI_FLAG:  regRdata <= {1'b0, flag_reg, 5'h00};
                `CMPC_ADDR_PERI_EN:    regRdata <= {1'b0, irqEn_reg, 5'h00};
                `CMPC_ADDR_IRQ_CTRL:   regRdata <= {gie_reg, peripheral_irq_enable_reg, 6'h00};
                `CMPC_ADDR_ROUTE_CTRL: regRdata <= {7'h00, route_reg};
                default:               regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end

endmodule : cmpc_top

//--- verilog/cmpc_params.svh
// Purpose: Register map, field positions and reset values of the comparator control block.
// Assumes: Byte-wide registers at their own addresses on a plain register port.
// Notes:   Included by the top module.
//
// Summary of operation
// - Comparator output levels read back as read-only control register bits.
// - Routing enabled: two port pins carry raw, unsynchronised comparator outputs.
// - Pin direction bits still gate the two routed output pins.
// - Two invert bits flip each comparator output polarity.
// - Timer gate comes from gate pin or comparator 2, chosen by select bit.
// - Sync enabled: comparator 2 latched on falling edge of timer clock.
// - With a prescaler, the latch edge is the prescaler output edge.
// - Timer counts on the rising edge, opposite to the latch edge.
// - Each comparator output change sets its own interrupt flag.
// - Flags clear only by software writing zero; writing one sets them.
// - Interrupt needs per-comparator, peripheral and global enables; flags set regardless.
// - Mismatch keeps setting the flag until control register read or written.
// - Change coinciding with a control register read may not set the flag.
// - Reference decodes 4-bit code in low or high range, 16 levels each.
// - Reference disabled with code zero gives ground and draws no current.
// - Comparators and reference run in sleep; interrupt wakes, vectors if global enable.
// - Wake from sleep leaves control, configuration and reference registers unchanged.
// - Reset restores all three registers: mode 000, reference off.
// - Output bit high when positive input exceeds negative, reversed when inverted.
`ifndef CMPC_PARAMS_SVH
`define CMPC_PARAMS_SVH

`define CMPC_ADDR_IRQ_CTRL   8'h0B
`define CMPC_ADDR_PERI_FLAG  8'h0D
`define CMPC_ADDR_PERI_EN    8'h8D
`define CMPC_ADDR_CMP_CONFIG 8'h97
`define CMPC_ADDR_CMP_CTRL   8'h9C
`define CMPC_ADDR_REF_CTRL   8'h9D
`define CMPC_ADDR_ROUTE_CTRL 8'h9E

`define CMPC_CTRL_RESET      8'h00
`define CMPC_CONFIG_RESET    8'h02
`define CMPC_REF_RESET       8'h00

// Field positions
`define CMPC_BIT_OUT2        7
`define CMPC_BIT_OUT1        6
`define CMPC_BIT_INV2        5
`define CMPC_BIT_INV1        4
`define CMPC_BIT_INSW        3
`define CMPC_BIT_GATE_SEL    1
`define CMPC_BIT_SYNC        0
`define CMPC_BIT_FLAG2       6
`define CMPC_BIT_FLAG1       5
`define CMPC_BIT_GIE         7
`define CMPC_BIT_PERIPHERAL_IRQ_ENABLE        6
`define CMPC_BIT_REF_EN      7
`define CMPC_BIT_REF_RANGE   5
`define CMPC_BIT_ROUTE_EN    0

// Reference ladder expressed in 1/96 of supply (common multiple of 24 and 32)
`define CMPC_REF_LOW_STEP    8'h04
`define CMPC_REF_HIGH_BASE   8'h18
`define CMPC_REF_HIGH_STEP   8'h03

// Writable bits of the reference register; bits 6 and 4 read as zero
`define CMPC_REF_WMASK       8'hAF

`endif

//--- verilog/cmpc_pkg.sv
// Purpose: Shared types of the comparator control block.
// Assumes: Constants come from cmpc_params.svh.
// Notes:   Types only.
package cmpc_pkg;

    typedef logic [7:0] cmpc_byte_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cmpc_req_s;

    // Reference ladder settings towards the analog side
    typedef struct packed {
        logic       ladderOn;
        logic       rangeLow;
        logic [3:0] levelCode;
        logic [7:0] level96;
    } cmpc_ref_s;

endpackage : cmpc_pkg

//--- tb/cmpc_timer_model.sv
// Purpose: Companion timer model: prescaled clock level and gated count.
// Assumes: Clock level held low in reset, so no edge appears at release.
// Notes:   halfPeriod picks a prompt or a slow timer clock.
`timescale 1ns/1ps
module cmpc_timer_model (
    input  logic        core_clk,
    input  logic        sys_rst,
    input  logic [3:0]  halfPeriod,
    input  logic        timerGate,
    input  logic        timerIncrement,
    output logic        timerClockLevel,
    output logic [15:0] gateCount
);
    logic [3:0] divCnt;
    always_ff @(posedge core_clk) begin
        divCnt <= (sys_rst || divCnt >= halfPeriod) ? 4'h0 : divCnt + 4'h1;
        if (sys_rst) timerClockLevel <= 1'b0;
        else if (divCnt >= halfPeriod) timerClockLevel <= ~timerClockLevel;
    end
    // Counts on the rising pulse only, gate settles on the falling one
    always_ff @(posedge core_clk) begin
        if (sys_rst) gateCount <= 16'h0000;
        else if (timerIncrement && timerGate) gateCount <= gateCount + 16'h0001;
    end
endmodule : cmpc_timer_model

//--- tb/cmpc_top_sva.sv
// Purpose: Port-level checks of the comparator control block.
// Assumes: Gate select shadow follows register writes.
// Notes:   Bound to cmpc_top.
`timescale 1ns/1ps
module cmpc_top_sva (
    input logic                core_clk,
    input logic                sys_rst,
    input cmpc_pkg::cmpc_req_s regReq,
    input logic [7:0]          regRdata,
    input logic [1:0]          pinDirectionBits,
    input logic                cmp1OutPinOe,
    input logic                cmp2OutPinOe,
    input logic                timerGatePin,
    input logic                timerClockLevel,
    input logic                timerGate,
    input logic                timerIncrement,
    input logic [2:0]          comparatorModeSelect,
    input cmpc_pkg::cmpc_ref_s referenceVoltageOut,
    input logic                sleepMode,
    input logic                cmpIrq,
    input logic                wakeRequest,
    input logic                vectorToIrq
);
    logic                gateSelReg;
    cmpc_pkg::cmpc_ref_s rv;
    assign rv = referenceVoltageOut;
    always_ff @(posedge core_clk) begin
        if (sys_rst) gateSelReg <= 1'b1;
        else if (regReq.wr && regReq.addr == 8'h97) gateSelReg <= regReq.wdata[1];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    rd_idle_a: assert property (!$past(regReq.rd) |-> regRdata == 8'h00)
        else $error("read data outside read slot");
    pin_oe_a: assert property ({cmp2OutPinOe, cmp1OutPinOe} == ~pinDirectionBits)
        else $error("pin enable wrong");
    gate_pin_a: assert property ((gateSelReg && $stable(timerGatePin)) [*3]
        |-> timerGate == timerGatePin) else $error("gate not from pin");
    inc_pulse_a: assert property (timerIncrement |=> !timerIncrement)
        else $error("increment longer than a cycle");
    inc_rise_a: assert property ($rose(timerClockLevel)
        |-> ##[0:1] timerIncrement) else $error("no increment on rising timer clock");
    irq_wake_a: assert property (cmpIrq && sleepMode
        |-> wakeRequest && vectorToIrq) else $error("interrupt in sleep did not wake");
    wake_cond_a: assert property (vectorToIrq |-> wakeRequest && sleepMode)
        else $error("vector without wake");
    ref_off_a: assert property (!rv.ladderOn |-> rv.level96 == 8'h00)
        else $error("disabled reference not at ground");
    ref_lvl_a: assert property (rv.ladderOn |-> rv.level96 == (rv.rangeLow ?
        {2'b00, rv.levelCode, 2'b00} : 8'h18 + 8'h03 * {4'h0, rv.levelCode}))
        else $error("reference level wrong");
    rst_val_a: assert property ($past(sys_rst)
        |-> comparatorModeSelect == 3'h0 && !rv.ladderOn) else $error("reset state wrong");
    cover property (vectorToIrq);
    cover property (timerIncrement && timerGate);
    cover property (regReq.wr && regReq.addr == 8'h0D && regReq.wdata == 8'h60);
endmodule : cmpc_top_sva
bind cmpc_top cmpc_top_sva u_sva (
    .core_clk             (core_clk),
    .sys_rst              (sys_rst),
    .regReq               (regReq),
    .regRdata             (regRdata),
    .pinDirectionBits     (pinDirectionBits),
    .cmp1OutPinOe         (cmp1OutPinOe),
    .cmp2OutPinOe         (cmp2OutPinOe),
    .timerGatePin         (timerGatePin),
    .timerClockLevel      (timerClockLevel),
    .timerGate            (timerGate),
    .timerIncrement       (timerIncrement),
    .comparatorModeSelect (comparatorModeSelect),
    .referenceVoltageOut  (referenceVoltageOut),
    .sleepMode            (sleepMode),
    .cmpIrq               (cmpIrq),
    .wakeRequest          (wakeRequest),
    .vectorToIrq          (vectorToIrq)
);

//--- tb/cmpc_top_bench.sv
// Purpose: Self-checking bench of the comparator control block.
// Assumes: Timer model drives the prescaled timer clock.
// Notes:   Read data checked by a monitor against a queue.
`timescale 1ns/1ps
module cmpc_top_bench;
    cmpc_pkg::cmpc_req_s regReq;
    cmpc_pkg::cmpc_ref_s refOut;
    logic [7:0]          regRdata, ctl, tmp, expQ[$];
    logic [15:0]         cnt, gateCount;
    logic [3:0]          halfPeriod;
    logic [2:0]          modeSel;
    logic [1:0]          dirBits, portData;
    logic                core_clk, sys_rst, cmp1Raw, cmp2Raw, gatePin, tClk, tGate, tInc;
    logic                sleepMode, pin1, pin1Oe, pin2, pin2Oe, cis, irq, wake, vec, rdSeen = 0;
    int                  n_mismatch = 0, n_tests = 0;
    cmpc_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .regReq(regReq), .regRdata(regRdata),
        .cmp1Raw(cmp1Raw), .cmp2Raw(cmp2Raw), .pinDirectionBits(dirBits), .portData(portData),
        .cmp1OutPin(pin1), .cmp1OutPinOe(pin1Oe), .cmp2OutPin(pin2), .cmp2OutPinOe(pin2Oe),
        .timerGatePin(gatePin), .timerClockLevel(tClk), .timerGate(tGate), .timerIncrement(tInc),
        .comparatorModeSelect(modeSel), .comparatorInputSwitch(cis), .referenceVoltageOut(refOut),
        .sleepMode(sleepMode), .cmpIrq(irq), .wakeRequest(wake), .vectorToIrq(vec));
    cmpc_timer_model u_timer (.core_clk(core_clk), .sys_rst(sys_rst), .halfPeriod(halfPeriod),
        .timerGate(tGate), .timerIncrement(tInc), .timerClockLevel(tClk), .gateCount(gateCount));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
    always @(posedge core_clk) begin
        if (rdSeen) chk(regRdata, expQ.pop_front());
        rdSeen <= regReq.rd;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) n_mismatch++;
        if (seen !== exp) $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    endtask : chk
    // Read when w is low: d is then the expected data
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        if (!w) expQ.push_back(d);
        @(posedge core_clk);
        regReq <= '{a, w ? d : 8'h00, w, !w};
        @(posedge core_clk);
        regReq <= '0;
    endtask : acc
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle
    task automatic waitLvl(input logic v);
        for (int k = 0; k < 40 && tClk !== v; k++) @(posedge core_clk);
    endtask : waitLvl
    function automatic logic [7:0] c9c();
        return {cmp2Raw ^ ctl[5], cmp1Raw ^ ctl[4], ctl[5:0]};
    endfunction : c9c
    task automatic resetChk();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        ctl = 8'h00;
        repeat (3) @(posedge core_clk);
        acc(8'h9C, c9c(), 0);
        acc(8'h97, 8'h02, 0);
        acc(8'h9D, 8'h00, 0);
        acc(8'h55, 8'h00, 0);
        $display("reset test done");
    endtask : resetChk
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        regReq = '0;
        sys_rst = 1'b1;
        {cmp1Raw, cmp2Raw, gatePin, sleepMode, dirBits, portData} = 8'h00;
        halfPeriod = 4'h1;
        void'($urandom(28218));
        resetChk();
        for (int i = 0; i < 6; i++) begin
            tmp = 8'($urandom);
            ctl = {2'b00, tmp[5:0]};
            acc(8'h9C, tmp, 1);
            {cmp2Raw, cmp1Raw, portData} <= 4'($urandom);
            settle(3);
            chk({cis, modeSel}, ctl[3:0]);
            acc(8'h9C, c9c(), 0);
        end
        $display("readback test done");
        ctl = 8'h00;
        acc(8'h9C, ctl, 1);
        settle(3);
        acc(8'h9C, c9c(), 0);
        acc(8'h0D, 8'h00, 1);
        acc(8'h0D, 8'h00, 0);
        cmp1Raw <= ~cmp1Raw;
        settle(4);
        acc(8'h0D, 8'h20, 0);
        acc(8'h0D, 8'h00, 1);
        acc(8'h0D, 8'h20, 0);
        acc(8'h9C, c9c(), 0);
        acc(8'h0D, 8'h00, 1);
        acc(8'h0D, 8'h00, 0);
        acc(8'h0D, 8'h60, 1);
        acc(8'h0D, 8'h60, 0);
        acc(8'h8D, 8'h60, 1);
        acc(8'h0B, 8'h40, 1);
        sleepMode <= 1'b1;
        settle(1);
        chk(irq, 1'b0);
        chk(vec, 1'b0);
        chk(wake, 1'b1);
        acc(8'h0B, 8'hC0, 1);
        settle(1);
        chk(vec, 1'b1);
        chk(irq, 1'b1);
        ctl = 8'h07;
        acc(8'h9C, ctl, 1);
        acc(8'h9D, 8'h00, 1);
        sleepMode <= 1'b0;
        settle(2);
        chk(modeSel, 3'h7);
        acc(8'h9C, c9c(), 0);
        $display("flag and sleep test done");
        for (int i = 0; i < 8; i++) begin
            tmp = (i == 0) ? 8'h00 : (i == 1) ? 8'hAF : (i == 2) ? 8'h8A : 8'($urandom);
            acc(8'h9D, tmp, 1);
            settle(1);
            chk(refOut.level96, !tmp[7] ? 8'h00 : tmp[5] ? {2'b00, tmp[3:0], 2'b00}
                : 8'h18 + {4'h0, tmp[3:0]} * 8'h03);
            chk({refOut.ladderOn, refOut.rangeLow, refOut.levelCode},
                {tmp[7], tmp[5], tmp[3:0]});
            acc(8'h9D, tmp & 8'hAF, 0);
        end
        $display("reference test done");
        chk({pin2, pin1}, portData);
        acc(8'h9E, 8'h01, 1);
        for (int j = 0; j < 4; j++) begin
            dirBits <= 2'(j);
            cmp2Raw <= ~cmp2Raw;
            #1;
            chk(pin2, cmp2Raw ^ ctl[5]);
            chk(pin1, cmp1Raw ^ ctl[4]);
            chk(2'({pin2Oe, pin1Oe}), 2'(~dirBits));
            @(posedge core_clk);
        end
        acc(8'h97, 8'h02, 1);
        cnt = gateCount;
        settle(20);
        chk(gateCount, cnt);
        @(posedge core_clk);
        gatePin <= 1'b1;
        settle(3);
        chk(tGate, 1'b1);
        cnt = gateCount;
        settle(20);
        chk(gateCount > cnt, 1'b1);
        acc(8'h97, 8'h00, 1);
        halfPeriod <= 4'h8;
        settle(3);
        chk(tGate, cmp2Raw ^ ctl[5]);
        acc(8'h97, 8'h01, 1);
        waitLvl(1'b0);
        waitLvl(1'b1);
        tmp[0] = cmp2Raw;
        cmp2Raw <= ~cmp2Raw;
        settle(3);
        chk(tGate, tmp[0]);
        waitLvl(1'b0);
        settle(3);
        chk(tGate, !tmp[0]);
        $display("pin and gate test done");
        resetChk();
        tally_and_finish();
    end
endmodule : cmpc_top_bench
